// *** shared/usc_cfg.svh ***
// Register offsets, field positions and timing counts of the serial core
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define USC_A_STATUS   4'h0
`define USC_A_CTRL1    4'h1
`define USC_A_CTRL2    4'h2
`define USC_A_CTRL3    4'h3
`define USC_A_DATA     4'h4
`define USC_A_BAUD_DIVISOR_HIGH     4'h5
`define USC_A_BAUD_DIVISOR_LOW     4'h6
`define USC_A_FIFOC    4'h7
`define USC_A_COUNT    4'h8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define USC_STATUS_RST 8'h0B
`define USC_BYTE_ZERO  8'h00

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define USC_S_PARITY_ERROR_FLAG     7
`define USC_S_NOISE    6
`define USC_S_FRAMING_ERROR_FLAG     5
`define USC_S_OVR      4
`define USC_S_RECEIVER_IDLE_FLAG    3
`define USC_S_RXAV     2
`define USC_S_TRANSMITTER_IDLE_FLAG    1
`define USC_S_TXE      0

// ----------------------------------------------------------------
// Control one bits
// ----------------------------------------------------------------
`define USC_C1_EN      7
`define USC_C1_NINE    6
`define USC_C1_PEN     5
`define USC_C1_PTH     4
`define USC_C1_PTL     3
`define USC_C1_BRK     2
`define USC_C1_RX8     1
`define USC_C1_TX8     0

// ----------------------------------------------------------------
// Control two, three and FIFO control bits
// ----------------------------------------------------------------
`define USC_C2_TRANSMITTER_ENABLE    7
`define USC_C2_RECEIVER_ENABLE    6
`define USC_C2_STOPS   5
`define USC_C2_RIE     2
`define USC_C3_SWM     0
`define USC_FC_TRG_HI  1
`define USC_FC_TRG_LO  0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define USC_OVS_LAST   4'hF
`define USC_OVS_MID    4'h8
`define USC_BRK_BITS   4'hD
`define USC_TX_STOPS   4'h2

`endif

// *** shared/usc_pkg.sv ***
// Types shared by the serial status and control core
`default_nettype none
package usc_pkg;

  // Transmit sequencer, Gray along idle-shift-break
  typedef enum logic [1:0] {
    USC_TX_IDLE  = 2'b00,
    USC_TX_SHIFT = 2'b01,
    USC_TX_BREAK = 2'b11
  } usc_tx_state_t;

  // Receive sequencer, Gray along idle-start-data-stop
  typedef enum logic [1:0] {
    USC_RX_IDLE  = 2'b00,
    USC_RX_START = 2'b01,
    USC_RX_DATA  = 2'b11,
    USC_RX_STOP  = 2'b10
  } usc_rx_state_t;

  // One received character as held in the receive buffer
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } usc_rx_entry_t;

endpackage
`default_nettype wire

// *** verilog/usc_core.sv ***
// Serial transmitter/receiver with status flags and global control
//
// The address-and-strobe port and the address map were left to the implementer.
`include "usc_cfg.svh"
`default_nettype none

// How it works
// [R1] Written byte moves to transmit shifter, sent LSB first at baud rate.
// [R2] Received bits shift in LSB first, whole character goes to data register.
// [R3] One shared data register; shift registers are not addressable.
// [R4] Status is read-only; resets to receiver idle, transmitter idle, empty.
// [R5] Parity mismatch against selected type sets parity error flag.
// [R6] Noise flag set with the character, never for an overrun character.
// [R7] Bad stop bit of current character sets framing error flag.
// [R8] Full buffer sets overrun; it blocks further transfers while set.
// [R9] Error flags clear by status read then shared data access.
// [R10] Receiver idle low from start bit detection to stop bit end; here it returns high at the middle sample of the last stop bit.
// [R11] Receive-available at trigger level; raises request when enabled.
// [R12] Errors flagged in the same cycle the character is transferred.
// [R13] Receive-available clears after status read, data read, buffer empty; here it clears once the count drops below the trigger.
// [R14] Transmitter idle when empty and nothing sent; pin rests high.
// [R15] Transmitter idle clears on status read then data write.
// [R16] Transmit empty set on move to shifter or enable; cleared like idle.
// [R17] Global disable floats pins, drops buffers, resets baud, aborts.
// [R18] While disabled enables, break, flags, count clear; idles set.
// [R19] Re-enable resumes with kept setup and pin roles per selects.
// [R20] Eight or nine bit characters; ninth bits in dedicated fields.
// [R21] With parity the last character bit carries parity, not data.
// [R22] Parity type: even, odd, forced one, forced zero.
// [R23] Break holds line low at least thirteen bits, until cleared.
// [R24] Transmitter sends two stop bits; receiver takes one or two.
// [R25] Frame: low start, data, optional parity, high stops, high idle.
module usc_core #(
  parameter int RX_DEPTH = 4
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            tx_pin_out,
  output logic            tx_pin_oe,
  input  wire logic       rxtx_pin_in,
  output logic            rxtx_pin_out,
  output logic            rxtx_pin_oe,
  output logic            rx_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // [R22] parity type select
  function automatic logic par_bit(input logic [1:0] ptype,
                                   input logic [7:0] d);
    unique case (ptype)
      2'b00: par_bit = ^d;
      2'b01: par_bit = ~^d;
      2'b10: par_bit = 1'b1;
      2'b11: par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  localparam int PW = $clog2(RX_DEPTH);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]              ctrl1_r, ctrl2_r, ctrl3_r, fifoc_r;
  logic [7:0]              baud_divisor_high_r, baud_divisor_low_r;
  logic [15:0]             baud_cnt_r;
  logic                    tick;
  logic                    enabled, tx_on, rx_on;
  logic                    st_rd, dat_rd, dat_wr, armed_r;
  logic [1:0]              ptype;
  logic                    nine, pen;
  usc_pkg::usc_tx_state_t  tx_st_r;
  logic [11:0]             tx_sh_r;
  logic [3:0]              tx_bits_r, tx_ovs_r;
  logic [7:0]              tx_buf_r;
  logic                    tx_full_r, txe_r, transmitter_idle_flag_r, tx_line;
  logic                    tx_bit_end;
  usc_pkg::usc_rx_state_t  rx_st_r;
  logic [3:0]              rx_ovs_r, rx_bits_r;
  logic [8:0]              rx_sh_r;
  logic [2:0]              samp_r;
  logic                    rx_line, rx_mid, rx_end, bit_val, bit_noisy;
  logic                    noise_acc_r, framing_error_flag_acc_r, stop2_r;
  logic                    rx_done;
  logic [8:0]              rx_char;
  logic                    par_bad;
  usc_pkg::usc_rx_entry_t  fifo_mem [RX_DEPTH];
  logic [PW-1:0]           wp_r, rp_r;
  logic [PW:0]             cnt_r;
  logic                    push, pop, fifo_full;
  logic [PW:0]             trig;
  logic                    rxav;
  logic                    parity_error_flag_r, nf_r, framing_error_flag_r, ovr_r;
  logic [7:0]              status;

  assign enabled = ctrl1_r[`USC_C1_EN];
  assign tx_on   = enabled & ctrl2_r[`USC_C2_TRANSMITTER_ENABLE];
  assign rx_on   = enabled & ctrl2_r[`USC_C2_RECEIVER_ENABLE];
  assign nine    = ctrl1_r[`USC_C1_NINE];
  assign pen     = ctrl1_r[`USC_C1_PEN];
  assign ptype   = {ctrl1_r[`USC_C1_PTH], ctrl1_r[`USC_C1_PTL]};
  assign st_rd   = reg_rd & (reg_addr == `USC_A_STATUS);
  assign dat_rd  = reg_rd & (reg_addr == `USC_A_DATA);
  assign dat_wr  = reg_wr & (reg_addr == `USC_A_DATA);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r <= `USC_BYTE_ZERO;
      ctrl2_r <= `USC_BYTE_ZERO;
      ctrl3_r <= `USC_BYTE_ZERO;
      fifoc_r <= `USC_BYTE_ZERO;
      baud_divisor_high_r  <= `USC_BYTE_ZERO;
      baud_divisor_low_r  <= `USC_BYTE_ZERO;
    end else begin
      if (reg_wr) begin
        unique case (reg_addr)
          `USC_A_CTRL1: ctrl1_r <= reg_wdata;
          `USC_A_CTRL2: ctrl2_r <= reg_wdata;
          `USC_A_CTRL3: ctrl3_r <= reg_wdata;
          `USC_A_FIFOC: fifoc_r <= reg_wdata;
          `USC_A_BAUD_DIVISOR_HIGH:  baud_divisor_high_r  <= reg_wdata;
          `USC_A_BAUD_DIVISOR_LOW:  baud_divisor_low_r  <= reg_wdata;
          default: ;
        endcase
      end
      // [R18] disable clears enables
      if (!enabled) begin
        ctrl2_r[`USC_C2_TRANSMITTER_ENABLE] <= 1'b0;
        ctrl2_r[`USC_C2_RECEIVER_ENABLE] <= 1'b0;
        ctrl1_r[`USC_C1_BRK]  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud generator, one tick per oversample slot
  // ----------------------------------------------------------------
  assign tick = (baud_cnt_r == {baud_divisor_high_r, baud_divisor_low_r});

  // [R17] disable resets counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_r <= '0;
    end else if (!enabled || tick) begin
      baud_cnt_r <= '0;
    end else begin
      baud_cnt_r <= baud_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign tx_bit_end = tick & (tx_ovs_r == `USC_OVS_LAST);

  // [R1] buffer to shifter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r   <= usc_pkg::USC_TX_IDLE;
      tx_sh_r   <= '1;
      tx_bits_r <= '0;
      tx_ovs_r  <= '0;
      tx_buf_r  <= `USC_BYTE_ZERO;
      tx_full_r <= 1'b0;
    end else if (!tx_on) begin
      // [R17] abort and discard
      tx_st_r   <= usc_pkg::USC_TX_IDLE;
      tx_full_r <= 1'b0;
      tx_ovs_r  <= '0;
    end else begin
      if (dat_wr) begin
        tx_buf_r  <= reg_wdata;
        tx_full_r <= 1'b1;
      end
      if (tick) begin
        tx_ovs_r <= tx_ovs_r + 4'h1;
      end
      unique case (tx_st_r)
        usc_pkg::USC_TX_IDLE: begin
          tx_ovs_r <= '0;
          if (tx_full_r) begin
            // [R25] start, data, parity or ninth, two stops
            // [R24] always two stop bits
            // [R21] parity takes the last character bit
            tx_full_r <= dat_wr;
            tx_st_r   <= usc_pkg::USC_TX_SHIFT;
            if (nine) begin
              tx_sh_r <= {2'b11,
                          pen ? par_bit(ptype, tx_buf_r)
                              : ctrl1_r[`USC_C1_TX8],
                          tx_buf_r, 1'b0};
              tx_bits_r <= 4'd1 + 4'd9 + `USC_TX_STOPS;
            end else begin
              tx_sh_r <= {3'b111,
                          pen ? par_bit(ptype, {1'b0, tx_buf_r[6:0]})
                              : tx_buf_r[7],
                          tx_buf_r[6:0], 1'b0};
              tx_bits_r <= 4'd1 + 4'd8 + `USC_TX_STOPS;
            end
          end else if (ctrl1_r[`USC_C1_BRK]) begin
            // [R23] break after buffered data
            tx_st_r   <= usc_pkg::USC_TX_BREAK;
            tx_bits_r <= `USC_BRK_BITS;
          end
        end
        usc_pkg::USC_TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
            if (tx_bits_r == 4'h1) begin
              tx_st_r <= usc_pkg::USC_TX_IDLE;
            end
          end
        end
        usc_pkg::USC_TX_BREAK: begin
          // [R23] at least thirteen bits and until cleared
          if (tx_bit_end && tx_bits_r != 4'h0) begin
            tx_bits_r <= tx_bits_r - 4'h1;
          end
          if (tx_bits_r == 4'h0 && !ctrl1_r[`USC_C1_BRK]) begin
            tx_st_r <= usc_pkg::USC_TX_IDLE;
          end
        end
        default: tx_st_r <= usc_pkg::USC_TX_IDLE;
      endcase
    end
  end

  // [R14] line high when idle
  assign tx_line = (tx_st_r == usc_pkg::USC_TX_SHIFT) ? tx_sh_r[0] :
                   (tx_st_r == usc_pkg::USC_TX_BREAK) ? 1'b0 : 1'b1;

  // [R16] empty flag set on move or enable; armed write clears
  // [R15] idle flag cleared by armed write, raised only with nothing queued
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txe_r   <= 1'b1;
      transmitter_idle_flag_r <= 1'b1;
    end else if (!tx_on) begin
      txe_r   <= 1'b1;
      transmitter_idle_flag_r <= 1'b1;
    end else begin
      if (tx_st_r == usc_pkg::USC_TX_IDLE && tx_full_r) begin
        txe_r <= 1'b1;
      end else if (armed_r && dat_wr) begin
        txe_r <= 1'b0;
      end
      if (txe_r && !tx_full_r && !dat_wr && !ctrl1_r[`USC_C1_BRK] &&
          tx_st_r == usc_pkg::USC_TX_IDLE) begin
        transmitter_idle_flag_r <= 1'b1;
      end else if (armed_r && dat_wr) begin
        transmitter_idle_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  assign rx_line   = rx_on ? rxtx_pin_in : 1'b1;
  assign rx_mid    = tick & (rx_ovs_r == `USC_OVS_MID);
  assign rx_end    = tick & (rx_ovs_r == `USC_OVS_LAST);
  assign bit_val   = maj3({samp_r[1:0], rx_line});
  assign bit_noisy = ~(&{samp_r[1:0], rx_line}) & (|{samp_r[1:0], rx_line});

  // [R21] parity bit held back from the delivered fields
  always_comb begin
    if (nine) begin
      rx_char = pen ? {1'b0, rx_sh_r[7:0]} : rx_sh_r;
      par_bad = pen & (rx_sh_r[8] != par_bit(ptype, rx_sh_r[7:0]));
    end else begin
      rx_char = pen ? {2'b00, rx_sh_r[7:1]} : {1'b0, rx_sh_r[8:1]};
      par_bad = pen &
                (rx_sh_r[8] != par_bit(ptype, {1'b0, rx_sh_r[7:1]}));
    end
  end

  // [R2] shift in LSB first
  // [R10] non-idle from start detection to the middle sample of the last stop bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r     <= usc_pkg::USC_RX_IDLE;
      rx_ovs_r    <= '0;
      rx_bits_r   <= '0;
      rx_sh_r     <= '0;
      samp_r      <= '1;
      noise_acc_r <= 1'b0;
      framing_error_flag_acc_r  <= 1'b0;
      stop2_r     <= 1'b0;
      rx_done     <= 1'b0;
    end else if (!rx_on) begin
      rx_st_r <= usc_pkg::USC_RX_IDLE;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        samp_r   <= {samp_r[1:0], rx_line};
        rx_ovs_r <= rx_ovs_r + 4'h1;
      end
      unique case (rx_st_r)
        usc_pkg::USC_RX_IDLE: begin
          rx_ovs_r <= '0;
          if (!rx_line) begin
            rx_st_r     <= usc_pkg::USC_RX_START;
            noise_acc_r <= 1'b0;
            framing_error_flag_acc_r  <= 1'b0;
            stop2_r     <= 1'b0;
          end
        end
        usc_pkg::USC_RX_START: begin
          if (rx_mid) begin
            noise_acc_r <= bit_noisy;
            if (bit_val) begin
              rx_st_r <= usc_pkg::USC_RX_IDLE;
            end
          end
          if (rx_end) begin
            rx_st_r   <= usc_pkg::USC_RX_DATA;
            rx_bits_r <= nine ? 4'd9 : 4'd8;
          end
        end
        usc_pkg::USC_RX_DATA: begin
          if (rx_mid) begin
            rx_sh_r     <= {bit_val, rx_sh_r[8:1]};
            noise_acc_r <= noise_acc_r | bit_noisy;
            rx_bits_r   <= rx_bits_r - 4'h1;
          end
          if (rx_end && rx_bits_r == 4'h0) begin
            rx_st_r <= usc_pkg::USC_RX_STOP;
          end
        end
        usc_pkg::USC_RX_STOP: begin
          if (rx_mid) begin
            // [R7] low stop bit is a framing error
            // [R24] one or two receive stop bits
            framing_error_flag_acc_r  <= framing_error_flag_acc_r | ~bit_val;
            noise_acc_r <= noise_acc_r | bit_noisy;
            if (ctrl2_r[`USC_C2_STOPS] && !stop2_r) begin
              stop2_r <= 1'b1;
            end else begin
              rx_st_r <= usc_pkg::USC_RX_IDLE;
              rx_done <= 1'b1;
            end
          end
        end
        default: rx_st_r <= usc_pkg::USC_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  assign fifo_full = (cnt_r == (PW+1)'(RX_DEPTH));
  // [R8] overrun blocks transfers
  assign push      = rx_done & ~fifo_full & ~ovr_r;
  assign pop       = dat_rd & (cnt_r != '0);
  assign trig      = (PW+1)'(fifoc_r[`USC_FC_TRG_HI:`USC_FC_TRG_LO]) +
                     (PW+1)'(1);
  // [R11] available at trigger level
  // [R13] clears once the buffer drains below it
  assign rxav      = (cnt_r >= trig) | (fifo_full & (cnt_r != '0));
  assign rx_irq    = ctrl2_r[`USC_C2_RIE] & (rxav | ovr_r);

  always_ff @(posedge clock) begin
    if (push) begin
      fifo_mem[wp_r] <= usc_pkg::usc_rx_entry_t'(rx_char);
    end
  end

  // [R17] disable discards characters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (!rx_on) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + PW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + PW'(1);
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // ----------------------------------------------------------------
  // Error flags and clearing sequence
  // ----------------------------------------------------------------
  // [R9] status read arms, data access clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (st_rd) begin
      armed_r <= 1'b1;
    end else if (dat_rd || dat_wr) begin
      armed_r <= 1'b0;
    end
  end

  // [R12] errors flagged with the transfer
  // [R5] [R6] set wins over the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parity_error_flag_r <= 1'b0;
      nf_r   <= 1'b0;
      framing_error_flag_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else if (!enabled) begin
      parity_error_flag_r <= 1'b0;
      nf_r   <= 1'b0;
      framing_error_flag_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      if (armed_r && (dat_rd || dat_wr)) begin
        parity_error_flag_r <= 1'b0;
        nf_r   <= 1'b0;
        framing_error_flag_r <= 1'b0;
        ovr_r  <= 1'b0;
      end
      if (push) begin
        if (par_bad)     parity_error_flag_r <= 1'b1;
        if (noise_acc_r) nf_r   <= 1'b1;
        if (framing_error_flag_acc_r)  framing_error_flag_r <= 1'b1;
      end
      // [R8] overflow sets overrun
      if (rx_done && (fifo_full || ovr_r)) begin
        ovr_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // [R4] read-only status
  assign status = {parity_error_flag_r, nf_r, framing_error_flag_r, ovr_r,
                   rx_st_r == usc_pkg::USC_RX_IDLE,
                   rxav, transmitter_idle_flag_r, txe_r};

  // [R3] only the shared data register is visible
  // [R20] ninth received bit read-only, transmit ninth write-only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `USC_BYTE_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `USC_A_STATUS: reg_rdata <= enabled ? status : `USC_STATUS_RST;
        `USC_A_CTRL1:  reg_rdata <= {ctrl1_r[7:2],
                                     fifo_mem[rp_r].ninth & (cnt_r != '0),
                                     1'b0};
        `USC_A_CTRL2:  reg_rdata <= ctrl2_r;
        `USC_A_CTRL3:  reg_rdata <= {7'h00, ctrl3_r[`USC_C3_SWM]};
        `USC_A_DATA:   reg_rdata <= (cnt_r != '0) ? fifo_mem[rp_r].data
                                                  : `USC_BYTE_ZERO;
        `USC_A_BAUD_DIVISOR_HIGH:   reg_rdata <= baud_divisor_high_r;
        `USC_A_BAUD_DIVISOR_LOW:   reg_rdata <= baud_divisor_low_r;
        `USC_A_FIFOC:  reg_rdata <= {2'b00, fifoc_r[5:0]};
        `USC_A_COUNT:  reg_rdata <= 8'(cnt_r);
        default:       reg_rdata <= `USC_BYTE_ZERO;
      endcase
    end else begin
      reg_rdata <= `USC_BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // [R19] pin roles from single-wire select and enables
  // [R17] floating while disabled
  assign tx_pin_out   = tx_line;
  assign tx_pin_oe    = tx_on;
  assign rxtx_pin_out = tx_line;
  assign rxtx_pin_oe  = tx_on & ctrl3_r[`USC_C3_SWM] &
                        ~ctrl2_r[`USC_C2_RECEIVER_ENABLE];

endmodule
`default_nettype wire

// *** test/usc_core_monitor.sv ***
// Port checker for the serial core, bound to usc_core
`default_nettype none
module usc_core_monitor (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_pin_out,
  input wire logic       tx_pin_oe,
  input wire logic       rxtx_pin_in,
  input wire logic       rxtx_pin_out,
  input wire logic       rxtx_pin_oe,
  input wire logic       rx_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_off;
    reg_wr && reg_addr == 4'h1 && !reg_wdata[7];
  endsequence
  sequence s_stat;
    reg_rd && reg_addr == 4'h0;
  endsequence
  a_rdata_one: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_off_float: assert property (s_off |=> !tx_pin_oe && !rxtx_pin_oe)
    else $error("pins driven after disable");
  a_off_idle: assert property (s_off |=> ##1 tx_pin_out)
    else $error("line not high after disable");
  a_off_status: assert property (s_off ##[1:3] s_stat
    |=> reg_rdata == 8'h0B) else $error("status wrong after disable");
  a_wire_same: assert property (rxtx_pin_oe |-> tx_pin_oe &&
    rxtx_pin_out == tx_pin_out) else $error("single wire output differs");
  a_start_bit: assert property ($fell(tx_pin_out) && tx_pin_oe
    |-> (!tx_pin_out)[*8]) else $error("start bit too short");
  a_bit_hold: assert property ($rose(tx_pin_out) && tx_pin_oe
    |-> tx_pin_out[*8]) else $error("high bit too short");
  a_irq_mask: assert property (reg_wr && reg_addr == 4'h2
    && !reg_wdata[2] |=> !rx_irq) else $error("request not masked");
endmodule
bind usc_core usc_core_monitor u_mon (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_pin_out(tx_pin_out),
  .tx_pin_oe(tx_pin_oe), .rxtx_pin_in(rxtx_pin_in),
  .rxtx_pin_out(rxtx_pin_out), .rxtx_pin_oe(rxtx_pin_oe), .rx_irq(rx_irq));
`default_nettype wire

// *** test/usc_serial_peer.sv ***
// Far-end serial device: sends frames and captures the transmit line
`default_nettype none
module usc_serial_peer (
  input  wire logic clock,
  input  wire logic tx_line,
  output var logic  rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1;
  // bits LSB first, 16 clocks each
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      rx_line <= bits[i];
      repeat (15) @(posedge clock);
    end
  endtask
  task automatic grab(output logic [11:0] v, input int n, output bit ok);
    int t;
    v = '0;
    t = 0;
    while (tx_line !== 1'b0 && t < 4000) begin
      @(posedge clock);
      t++;
    end
    ok = (t < 4000);
    repeat (8) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      v[i] = tx_line;
      repeat (16) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// *** test/usc_core_test.sv ***
// Self-checking bench for the serial core
`include "usc_cfg.svh"
`default_nettype none
module usc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       tx_pin_out, tx_pin_oe, rxtx_pin_out, rxtx_pin_oe, rx_irq;
  logic       peer_line;
  wire logic  rxtx_pin_in = rxtx_pin_oe ? rxtx_pin_out : peer_line;
  int         mismatches = 0;
  int         check_count = 0;
  always #2.5 clock = ~clock;
  usc_core #(.RX_DEPTH(4)) DUT (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .rxtx_pin_in(rxtx_pin_in),
    .rxtx_pin_out(rxtx_pin_out), .rxtx_pin_oe(rxtx_pin_oe), .rx_irq(rx_irq));
  usc_serial_peer peer (.clock(clock),
    .tx_line(tx_pin_oe ? tx_pin_out : 1'b1), .rx_line(peer_line));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_tx;
    logic [7:0]  d;
    logic [11:0] v;
    bit          ok;
    rd(`USC_A_STATUS, d);
    chk(d, `USC_STATUS_RST);
    wr(`USC_A_STATUS, 8'hFF);
    rd(`USC_A_STATUS, d);
    chk(d, `USC_STATUS_RST);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h80);
    rd(4'h0, d);
    chk(rxtx_pin_oe, 1'b1);
    wr(4'h4, 8'hA5);
    peer.grab(v, 11, ok);
    chk({ok, v[10:0]}, {1'b1, 2'b11, 8'hA5, 1'b0});
    rd(4'h0, d);
    chk(d, 8'h0B);
    for (int p = 0; p < 4; p++) begin
      wr(4'h1, 8'hA0 | 8'(p << 3));
      rd(4'h0, d);
      wr(4'h4, 8'h35);
      peer.grab(v, 9, ok);
      chk({ok, v[8:0]}, {1'b1, (p == 1 || p == 2), 7'h35, 1'b0});
      repeat (40) @(posedge clock);
    end
    $display("transmit test done");
  endtask
  task automatic t_rx;
    logic [7:0] d;
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h44);
    chk(rxtx_pin_oe, 1'b0);
    peer.send({2'b11, 8'h3C, 1'b0}, 11);
    repeat (4) @(posedge clock);
    chk(rx_irq, 1'b1);
    rd(4'h0, d);
    chk(d, 8'h0F);
    rd(4'h4, d);
    chk(d, 8'h3C);
    rd(4'h0, d);
    chk(d, 8'h0B);
    peer.send({2'b10, 8'h55, 1'b0}, 11);
    rd(4'h0, d);
    chk(d & 8'h20, 8'h20);
    rd(4'h4, d);
    rd(4'h0, d);
    chk(d & 8'h20, 8'h00);
    for (int i = 0; i < 5; i++) peer.send({2'b11, 8'(i + 17), 1'b0}, 11);
    rd(4'h0, d);
    chk(d & 8'h10, 8'h10);
    rd(4'h4, d);
    chk(d, 8'h11);
    rd(4'h0, d);
    chk(d & 8'h10, 8'h00);
    wr(4'h2, 8'h40);
    @(posedge clock);
    chk(rx_irq, 1'b0);
    $display("receive test done");
  endtask
  task automatic t_off;
    logic [7:0] d;
    wr(4'h7, 8'h02);
    wr(4'h1, 8'h00);
    rd(4'h0, d);
    chk(d, 8'h0B);
    rd(4'h2, d);
    chk(d, 8'h00);
    rd(4'h7, d);
    chk(d, 8'h02);
    rd(4'h8, d);
    chk(d, 8'h00);
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h80);
    @(posedge clock);
    chk(tx_pin_oe, 1'b1);
    $display("disable test done");
  endtask
  task automatic t_nine;
    logic [7:0] d;
    wr(4'h1, 8'hE0);
    wr(4'h2, 8'h60);
    wr(4'h7, 8'h00);
    peer.send({2'b11, 1'b1, 8'h81, 1'b0}, 12);
    rd(4'h0, d);
    chk(d, 8'h8F);
    rd(4'h1, d);
    chk(d, 8'hE0);
    rd(4'h4, d);
    chk(d, 8'h81);
    rd(4'h0, d);
    chk(d, 8'h0B);
    $display("nine bit test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_tx();
    t_rx();
    t_off();
    t_nine();
    results();
  end
endmodule
`default_nettype wire
